// *** adc_ctl.sv ***
// Converter control: registers, clock choice, triggering, result format
// Behaviour
// - Channel field routes inputs 0-11, temperature, DAC, fixed reference.
// - Writing go bit starts conversion; bit reads one while busy.
// - Go bit clears itself when conversion finishes.
// - Enable bit powers converter; zero disables it entirely.
// - Right justified: upper six bits of high result are zero.
// - Left justified: lower six bits of low result are zero.
// - Clock select picks oscillator divide or internal RC clock.
// - Reference field selects supply, external pin or fixed reference.
// - Four-bit field selects auto-trigger source, zero means none.
// - Auto-trigger starts conversion only on rising edge of source.
// - Timer overflow used as trigger still sets timer flag.
// - Left justified: bits 9-2 high, bits 1-0 in low 7-6.
// - Right justified: bits 9-8 in high result bits 1-0.
// - Unimplemented control bits read zero.
// - Completion clears go, sets completion flag, loads result.
// - Early stop loads partial result, unconverted bits copy last bit; a stop while still sampling loads nothing.
// - Full conversion takes eleven and a half bit periods.
// - Right justified: bits 7-0 in low result register.
//
// Added by the designer: the APB slave port and the register addresses.
`default_nettype none
module adc_ctl #(
	parameter int RESULT_W = adc_ctl_pkg::RESULT_BITS,
	parameter int TRIG_N   = 16
) (
	// Clock, reset, enable
	input  wire logic                clk_i,
	input  wire logic                rst_b_i,
	input  wire logic                ce_i,
	// APB slave
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [7:0]          paddr_i,
	input  wire logic [31:0]         pwdata_i,
	output logic      [31:0]         prdata_o,
	output logic                     pready_o,
	output logic                     pslverr_o,
	// Trigger sources, index equals select code; 0 unused
	input  wire logic [TRIG_N-1:0]   trig_src_i,
	// Internal RC clock tick, asynchronous
	input  wire logic                rc_clk_i,
	// Analog front end
	input  wire logic                cmp_i,
	output adc_ctl_pkg::mux_sel_s    mux_sel_o,
	output adc_ctl_pkg::ref_sel_s    ref_sel_o,
	output logic                     analog_on_o,
	output logic                     sample_o,
	output logic [RESULT_W-1:0]      dac_trial_o,
	// Events
	output logic                     done_pulse_o,
	output logic                     timer_zero_wrap_o,
	output logic                     timer_one_wrap_o
);
	localparam logic [3:0] TRIG_T0 = 4'h3;
	localparam logic [3:0] TRIG_T1 = 4'h4;

	typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT} st_e;
	st_e st_q;

	logic [7:0] ctrl0_q;
	logic [7:0] ctrl1_q;
	logic [7:0] ctrl2_q;
	logic [7:0] res_hi_q;
	logic [7:0] res_lo_q;
	logic       done_flag_q;
	logic [5:0] div_cnt_q;
	logic [4:0] half_q;
	logic [RESULT_W-1:0] sar_q;
	logic [3:0] bit_q;
	logic       tgl_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        done_p_q;
	logic        t0_q;
	logic        t1_q;
	adc_ctl_pkg::mux_sel_s mux_q;
	adc_ctl_pkg::ref_sel_s ref_q;

	// Decode
	wire       setup     = psel_i && !penable_i;
	wire       wr        = setup && pwrite_i;
	wire       rd        = setup && !pwrite_i;
	wire       hit_c0    = paddr_i == adc_ctl_pkg::ADDR_CTRL0;
	wire       hit_c1    = paddr_i == adc_ctl_pkg::ADDR_CTRL1;
	wire       hit_c2    = paddr_i == adc_ctl_pkg::ADDR_CTRL2;
	wire       hit_rh    = paddr_i == adc_ctl_pkg::ADDR_RES_HI;
	wire       hit_rl    = paddr_i == adc_ctl_pkg::ADDR_RES_LO;
	wire       hit_st    = paddr_i == adc_ctl_pkg::ADDR_STATUS;
	wire       mapped    = hit_c0 | hit_c1 | hit_c2 | hit_rh | hit_rl | hit_st;
	wire       enabled   = ctrl0_q[adc_ctl_pkg::CTRL0_ENABLE_BIT];
	wire       go        = ctrl0_q[adc_ctl_pkg::CTRL0_GO_BIT];
	wire       right_j   = ctrl1_q[adc_ctl_pkg::CTRL1_FORMAT_BIT];
	wire [2:0] clk_sel   = ctrl1_q[6:4];
	wire [3:0] trig_sel  = ctrl2_q[7:4];
	wire [4:0] chan      = ctrl0_q[6:2];
	wire [7:0] wbyte     = pwdata_i[7:0];

	// Trigger edge detect per source
	logic [TRIG_N-1:0] trig_rise;
	logic [TRIG_N-1:0] trig_lvl;
	logic              rc_rise;
	genvar gi;
	generate
		for (gi = 0; gi < TRIG_N; gi++) begin : g_trig
			adc_edge_sync u_sync (
				.clk_i   (clk_i),
				.rst_b_i (rst_b_i),
				.ce_i    (ce_i),
				.async_i (trig_src_i[gi]),
				.level_o (trig_lvl[gi]),
				.rise_o  (trig_rise[gi])
			);
		end
	endgenerate
	adc_edge_sync u_rc (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.ce_i    (ce_i),
		.async_i (rc_clk_i),
		.level_o (),
		.rise_o  (rc_rise)
	);

	// Code zero selects no source
	wire auto_start = (trig_sel != 4'h0) && trig_rise[trig_sel] && enabled;
	// Timer wraps pass on to their own flags regardless of selection
	wire t0_evt = trig_rise[TRIG_T0];
	wire t1_evt = trig_rise[TRIG_T1];

	// Divider for oscillator-derived half bit period
	logic [5:0] div_half;
	always_comb begin
		case (clk_sel)
			3'h0: div_half = 6'(adc_ctl_pkg::DIV_2 / 2);
			3'h1: div_half = 6'(adc_ctl_pkg::DIV_8 / 2);
			3'h2: div_half = 6'(adc_ctl_pkg::DIV_32 / 2);
			3'h4: div_half = 6'(adc_ctl_pkg::DIV_4 / 2);
			3'h5: div_half = 6'(adc_ctl_pkg::DIV_16 / 2);
			3'h6: div_half = 6'(adc_ctl_pkg::DIV_64 / 2);
			default: div_half = 6'h01;
		endcase
	end
	wire use_rc   = clk_sel[1] && clk_sel[0];
	wire osc_tick = div_cnt_q == div_half - 6'h01;
	wire half_tick = use_rc ? rc_rise : osc_tick;

	// Software write to go, start from software or trigger
	wire sw_go_wr  = wr && hit_c0 && wbyte[adc_ctl_pkg::CTRL0_GO_BIT];
	wire sw_go_clr = wr && hit_c0 && !wbyte[adc_ctl_pkg::CTRL0_GO_BIT];
	wire start     = (st_q == IDLE) && enabled && (sw_go_wr || auto_start);
	wire abort     = (st_q != IDLE) && (sw_go_clr || !enabled);
	wire last_half = half_tick && (half_q == 5'(adc_ctl_pkg::HALF_PERIODS - 1));
	wire finish    = (st_q == CONVERT) && last_half;

	// Partial result: unconverted bits copy last decided bit
	logic [RESULT_W-1:0] partial;
	always_comb begin
		partial = sar_q;
		for (int i = 0; i < RESULT_W; i++) begin
			if (i <= 32'(bit_q) && bit_q < 4'(RESULT_W - 1)) begin
				partial[i] = sar_q[bit_q + 4'h1];
			end
		end
	end
	// Bit zero is decided in the same half period that finishes
	wire [RESULT_W-1:0] final_res = finish
		? {sar_q[RESULT_W-1:1], cmp_i} : partial;
	wire load_res = finish || (abort && st_q == CONVERT);

	// Result formatting
	wire [7:0] fmt_hi = right_j ? {6'h00, final_res[9:8]} : final_res[9:2];
	wire [7:0] fmt_lo = right_j ? final_res[7:0] : {final_res[1:0], 6'h00};

	// Register file and APB slave
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl0_q     <= adc_ctl_pkg::RESET_VAL;
			ctrl1_q     <= adc_ctl_pkg::RESET_VAL;
			ctrl2_q     <= adc_ctl_pkg::RESET_VAL;
			res_hi_q    <= adc_ctl_pkg::RESET_VAL;
			res_lo_q    <= adc_ctl_pkg::RESET_VAL;
			done_flag_q <= 1'b0;
			prdata_q    <= 32'h0000_0000;
			pready_q    <= 1'b0;
			pslverr_q   <= 1'b0;
		end else if (ce_i) begin
			pready_q  <= setup;
			pslverr_q <= setup && !mapped;
			if (rd) begin
				// Masks keep unimplemented bits at zero
				prdata_q <= 32'h0000_0000;
				if (hit_c0) prdata_q[7:0] <= ctrl0_q & adc_ctl_pkg::CTRL0_MASK;
				if (hit_c1) prdata_q[7:0] <= ctrl1_q & adc_ctl_pkg::CTRL1_MASK;
				if (hit_c2) prdata_q[7:0] <= ctrl2_q & adc_ctl_pkg::CTRL2_MASK;
				if (hit_rh) prdata_q[7:0] <= res_hi_q;
				if (hit_rl) prdata_q[7:0] <= res_lo_q;
				if (hit_st) prdata_q[adc_ctl_pkg::STATUS_DONE_BIT] <= done_flag_q;
			end
			if (wr && hit_c0) begin
				ctrl0_q <= wbyte & adc_ctl_pkg::CTRL0_MASK;
				// Go sets only when converter already enabled
				// A go write while busy keeps the running conversion
				ctrl0_q[adc_ctl_pkg::CTRL0_GO_BIT] <= start
					|| (sw_go_wr && st_q != IDLE && !finish);
			end else if (start) begin
				ctrl0_q[adc_ctl_pkg::CTRL0_GO_BIT] <= 1'b1;
			end else if (finish || abort) begin
				ctrl0_q[adc_ctl_pkg::CTRL0_GO_BIT] <= 1'b0;
			end
			if (wr && hit_c1) ctrl1_q <= wbyte & adc_ctl_pkg::CTRL1_MASK;
			if (wr && hit_c2) ctrl2_q <= wbyte & adc_ctl_pkg::CTRL2_MASK;
			// Hardware load beats a same-cycle software write
			if (load_res) begin
				res_hi_q <= fmt_hi;
				res_lo_q <= fmt_lo;
			end else begin
				if (wr && hit_rh) res_hi_q <= wbyte;
				if (wr && hit_rl) res_lo_q <= wbyte;
			end
			// Set wins over clear; write one clears
			if (finish) begin
				done_flag_q <= 1'b1;
			end else if (wr && hit_st && wbyte[adc_ctl_pkg::STATUS_DONE_BIT]) begin
				done_flag_q <= 1'b0;
			end
		end
	end

	// Conversion sequencer
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q      <= IDLE;
			div_cnt_q <= 6'h00;
			half_q    <= 5'h00;
			sar_q     <= '0;
			bit_q     <= 4'h0;
			tgl_q     <= 1'b0;
			done_p_q  <= 1'b0;
			t0_q      <= 1'b0;
			t1_q      <= 1'b0;
		end else if (ce_i) begin
			done_p_q <= finish;
			t0_q     <= t0_evt;
			t1_q     <= t1_evt;
			div_cnt_q <= (osc_tick || st_q == IDLE) ? 6'h00 : div_cnt_q + 6'h01;
			case (st_q)
				IDLE: begin
					if (start) begin
						st_q   <= SAMPLE;
						half_q <= 5'h00;
						sar_q  <= '0;
						bit_q  <= 4'(RESULT_W - 1);
						tgl_q  <= 1'b0;
					end
				end
				SAMPLE: begin
					// First one and a half bit periods (three half periods) hold the sample
					if (abort) begin
						st_q <= IDLE;
					end else if (half_tick) begin
						half_q <= half_q + 5'h01;
						if (half_q == 5'h02) begin
							st_q <= CONVERT;
							sar_q[bit_q] <= 1'b1;
						end
					end
				end
				CONVERT: begin
					if (abort || finish) begin
						st_q <= IDLE;
					end else if (half_tick) begin
						half_q <= half_q + 5'h01;
						tgl_q  <= !tgl_q;
						// Decide one bit each full period
						if (tgl_q && bit_q != 4'(RESULT_W)) begin
							sar_q[bit_q] <= cmp_i;
							if (bit_q != 4'h0) begin
								bit_q <= bit_q - 4'h1;
								sar_q[bit_q - 4'h1] <= 1'b1;
							end else begin
								bit_q <= 4'(RESULT_W);
							end
						end
					end
				end
				default: st_q <= IDLE;
			endcase
		end
	end

	// Front-end selection
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mux_q <= '0;
			ref_q <= '0;
		end else if (ce_i) begin
			mux_q.channel       <= chan;
			mux_q.internal_temp <= chan == adc_ctl_pkg::CHAN_TEMP;
			mux_q.internal_dac  <= chan == adc_ctl_pkg::CHAN_DAC;
			mux_q.internal_fvr  <= chan == adc_ctl_pkg::CHAN_FVR;
			mux_q.connected     <= chan <= adc_ctl_pkg::CHAN_EXT_LAST
				|| chan >= adc_ctl_pkg::CHAN_TEMP;
			ref_q.code      <= ctrl1_q[1:0];
			ref_q.on_supply <= ctrl1_q[1:0] == adc_ctl_pkg::REF_SUPPLY;
			ref_q.on_pin    <= ctrl1_q[1:0] == adc_ctl_pkg::REF_PIN;
			ref_q.on_fixed  <= ctrl1_q[1:0] == adc_ctl_pkg::REF_FIXED;
		end
	end

	assign prdata_o          = prdata_q;
	assign pready_o          = pready_q;
	assign pslverr_o         = pslverr_q;
	assign mux_sel_o         = mux_q;
	assign ref_sel_o         = ref_q;
	assign analog_on_o       = ctrl0_q[adc_ctl_pkg::CTRL0_ENABLE_BIT];
	assign sample_o          = st_q == SAMPLE;
	assign dac_trial_o       = sar_q;
	assign done_pulse_o      = done_p_q;
	assign timer_zero_wrap_o = t0_q;
	assign timer_one_wrap_o  = t1_q;
endmodule : adc_ctl
`default_nettype wire

// *** adc_ctl_bench.sv ***
// Self-checking bench for the converter control block
`default_nettype none
module adc_ctl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic       err;
	} row_s;
	localparam logic [9:0] LEVEL = 10'h2D4;
	// Abort after four decided bits: the rest copy the fourth
	localparam logic [9:0] PART  = {LEVEL[9:6], {6{LEVEL[6]}}};
	logic                  ce_i = 1'b1;
	logic                  rc_clk_i = 1'b0;
	logic                  clk_i = 1'b0;
	logic                  rst_b_i = 1'b0;
	logic                  psel_i = 1'b0;
	logic                  penable_i = 1'b0;
	logic                  pwrite_i = 1'b0;
	logic [7:0]            paddr_i = 8'h00;
	logic [31:0]           pwdata_i = 32'h00000000;
	logic [15:0]           trig_src_i = 16'h0000;
	logic [31:0]           prdata_o;
	logic                  pready_o;
	logic                  pslverr_o;
	logic                  cmp_i;
	adc_ctl_pkg::mux_sel_s mux_sel_o;
	adc_ctl_pkg::ref_sel_s ref_sel_o;
	logic                  analog_on_o;
	logic                  sample_o;
	logic [9:0]            dac_trial_o;
	logic                  done_pulse_o;
	logic                  timer_zero_wrap_o;
	logic                  timer_one_wrap_o;
	logic [31:0]           rd;
	logic                  er;
	int                    miscompares = 0;
	int                    checked = 0;
	int                    dones = 0;
	int                    wraps = 0;
	// Go with enable low must be refused, so 0x02 follows 0x00
	row_s rows [6] = '{'{8'h04, 8'hFF, 8'hF3, 1'b0},
		'{8'h08, 8'hFF, 8'hF0, 1'b0}, '{8'h00, 8'hFD, 8'h7D, 1'b0},
		'{8'h00, 8'h00, 8'h00, 1'b0}, '{8'h00, 8'h02, 8'h00, 1'b0},
		'{8'h18, 8'hFF, 8'h00, 1'b1}};
	adc_ctl i_adc_ctl (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o),
		.trig_src_i(trig_src_i), .rc_clk_i(rc_clk_i), .cmp_i(cmp_i),
		.mux_sel_o(mux_sel_o), .ref_sel_o(ref_sel_o),
		.analog_on_o(analog_on_o), .sample_o(sample_o),
		.dac_trial_o(dac_trial_o), .done_pulse_o(done_pulse_o),
		.timer_zero_wrap_o(timer_zero_wrap_o),
		.timer_one_wrap_o(timer_one_wrap_o));
	adc_front_model i_adc_front_model (.level_i(LEVEL),
		.trial_i(dac_trial_o), .cmp_o(cmp_i));
	always #4 clk_i = ~clk_i;
	// Free-running RC clock, rising edges coincide with bus clock rising edges
	always #52 rc_clk_i = ~rc_clk_i;
	// Pulses counted mid-cycle, clear of the launching edge
	always @(negedge clk_i) begin
		dones += int'(done_pulse_o === 1'b1);
		wraps += int'((timer_zero_wrap_o | timer_one_wrap_o) === 1'b1);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n;
		n = 0;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 50);
		if (pready_o !== 1'b1) miscompares++;
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask : apb
	task automatic convert(input logic [7:0] fmt, input logic [9:0] hl);
		int n;
		n = 0;
		apb(adc_ctl_pkg::ADDR_CTRL1, 1'b1, {24'h0, fmt});
		apb(adc_ctl_pkg::ADDR_STATUS, 1'b1, 32'h1);
		apb(adc_ctl_pkg::ADDR_CTRL0, 1'b1, 32'h1);
		repeat (8) @(posedge clk_i);
		apb(adc_ctl_pkg::ADDR_CTRL0, 1'b1, 32'h3);
		apb(adc_ctl_pkg::ADDR_CTRL0, 1'b0, 32'h0);
		chk(rd, 32'h3);
		do apb(8'h00, 1'b0, 32'h0);
		while (rd[1] !== 1'b0 && ++n < 200);
		chk(rd, 32'h1);
		apb(adc_ctl_pkg::ADDR_RES_HI, 1'b0, 32'h0);
		chk(rd, fmt[7] ? 32'(LEVEL[9:8]) : 32'(LEVEL[9:2]));
		apb(adc_ctl_pkg::ADDR_RES_LO, 1'b0, 32'h0);
		chk(rd, fmt[7] ? 32'(LEVEL[7:0]) : {24'h0, hl[1:0], 6'h0});
		apb(adc_ctl_pkg::ADDR_STATUS, 1'b0, 32'h0);
		chk(rd, 32'h1);
	endtask : convert
	task automatic conclude();
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		conclude();
	end
	initial begin
		int d0;
		int w0;
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		for (int a = 0; a < 12; a += 4) begin
			apb(8'(a), 1'b0, 32'h0);
			chk(rd, 32'h0);
		end
		foreach (rows[i]) begin
			apb(rows[i].addr, 1'b1, {24'h0, rows[i].wdata});
			chk(32'(er), 32'(rows[i].err));
			apb(rows[i].addr, 1'b0, 32'h0);
			chk({rd[30:0], er}, {23'h0, rows[i].rdata, rows[i].err});
		end
		$display("test registers done");
		convert(8'hB0, LEVEL);
		convert(8'h80, LEVEL);
		convert(8'h00, LEVEL);
		$display("test conversion done");
		apb(8'h00, 1'b1, 32'h1);
		for (int c = 0; c < 16; c++) begin
			apb(8'h08, 1'b1, 32'(c) << 4);
			d0 = dones;
			w0 = wraps;
			trig_src_i[c] <= 1'b1;
			repeat (60) @(posedge clk_i);
			chk(32'(dones - d0), 32'(c != 0));
			chk(32'(wraps - w0), 32'(c == 3 || c == 4));
			trig_src_i[c] <= 1'b0;
			repeat (6) @(posedge clk_i);
		end
		$display("test trigger done");
		apb(adc_ctl_pkg::ADDR_CTRL1, 1'b1, 32'hE0);
		apb(8'h00, 1'b1, 32'h3);
		repeat (380) @(posedge clk_i);
		apb(8'h00, 1'b1, 32'h1);
		apb(8'h00, 1'b0, 32'h0);
		chk(rd, 32'h1);
		apb(adc_ctl_pkg::ADDR_RES_HI, 1'b0, 32'h0);
		chk(rd, 32'(PART[9:8]));
		apb(adc_ctl_pkg::ADDR_RES_LO, 1'b0, 32'h0);
		chk(rd, 32'(PART[7:0]));
		$display("test abort done");
		apb(adc_ctl_pkg::ADDR_CTRL1, 1'b1, 32'h80);
		apb(8'h00, 1'b1, 32'h3);
		d0 = dones;
		ce_i <= 1'b0;
		repeat (40) @(posedge clk_i);
		chk(32'(dones - d0), 32'h0);
		ce_i <= 1'b1;
		repeat (40) @(posedge clk_i);
		chk(32'(dones - d0), 32'h1);
		$display("test freeze done");
		conclude();
	end
endmodule : adc_ctl_bench
`default_nettype wire

// *** adc_ctl_monitor.sv ***
// Port checks for the converter control block
`default_nettype none
module adc_ctl_monitor (
	// Clock and reset
	input wire logic                  clk_i,
	input wire logic                  rst_b_i,
	input wire logic                  ce_i,
	// Bus
	input wire logic                  psel_i,
	input wire logic                  penable_i,
	input wire logic                  pwrite_i,
	input wire logic [7:0]            paddr_i,
	input wire logic [31:0]           pwdata_i,
	input wire logic [31:0]           prdata_o,
	input wire logic                  pready_o,
	input wire logic                  pslverr_o,
	// Converter side
	input wire adc_ctl_pkg::mux_sel_s mux_sel_o,
	input wire adc_ctl_pkg::ref_sel_s ref_sel_o,
	input wire logic                  analog_on_o,
	input wire logic                  done_pulse_o,
	input wire logic                  timer_zero_wrap_o
);
	// Data held through access, so one stage is enough
	logic [31:0] wd_q;
	always_ff @(posedge clk_i) wd_q <= pwdata_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_setup;
		psel_i && !penable_i && ce_i;
	endsequence
	sequence s_wr0;
		s_setup ##0 pwrite_i && paddr_i == adc_ctl_pkg::ADDR_CTRL0;
	endsequence
	sequence s_wr1;
		s_setup ##0 pwrite_i && paddr_i == adc_ctl_pkg::ADDR_CTRL1;
	endsequence
	a_setup_answer: assert property (s_setup |=> pready_o)
		else $error("no ready after setup");
	a_ready_single: assert property (pready_o && ce_i |=> !pready_o)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	a_upper_zero: assert property (
		pready_o |-> prdata_o[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	a_enable_follow: assert property (
		s_wr0 |-> ##2 analog_on_o == wd_q[0])
		else $error("enable output mismatch");
	a_chan_route: assert property (
		s_wr0 |-> ##2 mux_sel_o.channel == wd_q[6:2]
		&& mux_sel_o.internal_fvr == (wd_q[6:2] == 5'h1F)
		&& mux_sel_o.internal_temp == (wd_q[6:2] == 5'h1D))
		else $error("channel routing mismatch");
	a_ref_route: assert property (
		s_wr1 |-> ##2 ref_sel_o.code == wd_q[1:0]
		&& ref_sel_o.on_fixed == (wd_q[1:0] == 2'h3))
		else $error("reference routing mismatch");
	a_done_single: assert property (
		done_pulse_o |=> !done_pulse_o)
		else $error("completion pulse too long");
	a_wrap_single: assert property (
		timer_zero_wrap_o |=> !timer_zero_wrap_o)
		else $error("timer flag pulse too long");
endmodule : adc_ctl_monitor
bind adc_ctl adc_ctl_monitor i_adc_ctl_monitor (.clk_i, .rst_b_i, .ce_i,
	.psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
	.pready_o, .pslverr_o, .mux_sel_o, .ref_sel_o, .analog_on_o,
	.done_pulse_o, .timer_zero_wrap_o);
`default_nettype wire

// *** adc_ctl_pkg.sv ***
// Package with register map, field layout and timing constants
`default_nettype none
package adc_ctl_pkg;
	// Register byte addresses on APB
	localparam logic [7:0] ADDR_CTRL0   = 8'h00;
	localparam logic [7:0] ADDR_CTRL1   = 8'h04;
	localparam logic [7:0] ADDR_CTRL2   = 8'h08;
	localparam logic [7:0] ADDR_RES_HI  = 8'h0C;
	localparam logic [7:0] ADDR_RES_LO  = 8'h10;
	localparam logic [7:0] ADDR_STATUS  = 8'h14;
	// Field positions
	localparam int CTRL0_ENABLE_BIT = 0;
	localparam int CTRL0_GO_BIT     = 1;
	localparam int CTRL1_FORMAT_BIT = 7;
	localparam int STATUS_DONE_BIT  = 0;
	// Writable masks (unimplemented bits read zero)
	localparam logic [7:0] CTRL0_MASK = 8'h7F;
	localparam logic [7:0] CTRL1_MASK = 8'hF3;
	localparam logic [7:0] CTRL2_MASK = 8'hF0;
	localparam logic [7:0] RESET_VAL  = 8'h00;
	// Channel codes
	localparam logic [4:0] CHAN_EXT_LAST = 5'h0B;
	localparam logic [4:0] CHAN_TEMP     = 5'h1D;
	localparam logic [4:0] CHAN_DAC      = 5'h1E;
	localparam logic [4:0] CHAN_FVR      = 5'h1F;
	// Reference codes
	localparam logic [1:0] REF_SUPPLY = 2'h0;
	localparam logic [1:0] REF_PIN    = 2'h2;
	localparam logic [1:0] REF_FIXED  = 2'h3;
	// Conversion timing in half bit periods: 11.5 periods
	localparam int HALF_PERIODS = 23;
	localparam int RESULT_BITS  = 10;
	// Clock divider ratios from the oscillator
	localparam int DIV_2  = 2;
	localparam int DIV_4  = 4;
	localparam int DIV_8  = 8;
	localparam int DIV_16 = 16;
	localparam int DIV_32 = 32;
	localparam int DIV_64 = 64;
	typedef enum logic [1:0] {SRC_OSC, SRC_RC} clk_src_e;
	typedef struct packed {
		logic [4:0] channel;
		logic       internal_temp;
		logic       internal_dac;
		logic       internal_fvr;
		logic       connected;
	} mux_sel_s;
	typedef struct packed {
		logic [1:0] code;
		logic       on_supply;
		logic       on_pin;
		logic       on_fixed;
	} ref_sel_s;
endpackage : adc_ctl_pkg
`default_nettype wire

// *** adc_edge_sync.sv ***
// Three-stage synchroniser with agreement-based rising edge detect
`default_nettype none
module adc_edge_sync (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic ce_i,
	// Asynchronous level in, rising pulse out
	input  wire logic async_i,
	output logic      level_o,
	output logic      rise_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_q;

	// First stage feeds only the second
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			lvl_q <= 1'b0;
		end else if (ce_i) begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				lvl_q <= s3_q;
			end
		end
	end

	assign level_o = lvl_q;
	assign rise_o  = ce_i && (s2_q == s3_q) && s3_q && !lvl_q;
endmodule : adc_edge_sync
`default_nettype wire

// *** adc_front_model.sv ***
// Comparator model of the analog front end
`default_nettype none
module adc_front_model (
	// Held input level and trial word
	input wire logic [9:0] level_i,
	input wire logic [9:0] trial_i,
	// Decision, keep bit when high
	output logic           cmp_o
);
	timeunit 1ns;
	timeprecision 1ps;
	assign cmp_o = level_i >= trial_i;
endmodule : adc_front_model
`default_nettype wire
